// File: rtl/mss_pkg.sv
package mss_pkg;

  // slot-select word as shifted in by the master, most significant bit first
  localparam int unsigned SEL_W = 16;
  localparam int unsigned SLOT_LSB = 0;
  localparam int unsigned SLOT_W = 5;
  localparam int unsigned CHAS_LSB = 8;
  localparam int unsigned CHAS_W = 5;

  // configuration shift register and identification register
  localparam int unsigned CFG_W = 16;
  localparam int unsigned ID_W = 32;

  // channel multiplexer counter
  localparam int unsigned MUX_W = 2;

  // factory-default chassis address: such a chassis takes any chassis number
  localparam logic [CHAS_W-1:0] CHAS_ANY = 5'h00;

  // reset values
  localparam logic [SEL_W-1:0] SEL_RST = 16'h0000;
  localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;

  // data_address_select levels
  localparam logic DAS_DATA = 1'b0;
  localparam logic DAS_ADDR = 1'b1;

  // synchroniser depths
  localparam int unsigned SYNC_W = 2;
  localparam int unsigned SCAN_W = 3;

  // state clocked by serial_shift_clock
  typedef struct packed {
    logic [SEL_W-1:0] slot_sh;
    logic [CFG_W-1:0] cfg_sh;
    logic [ID_W-1:0] id_sh;
    logic out_bit;
  } mss_link_s;

  // state clocked by sys_clk
  typedef struct packed {
    logic [SYNC_W-1:0] strb_sync;
    logic [SCAN_W-1:0] scan_sync;
    logic [SEL_W-1:0] slot_cap;
    logic selected;
    logic [CFG_W-1:0] cfg_lat;
    logic [MUX_W-1:0] mux_cnt;
  } mss_sys_s;

  // parallel outputs that travel together
  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [MUX_W-1:0] mux;
  } mss_ctl_s;

endpackage

// File: rtl/mss_serial_port.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////

// Summary of operation
// - each rising scan_advance_clock edge adds one to the channel mux counter.
// - strobe low starts slot-select and removes select from every module.
// - every serial bit is sampled on the rising serial shift clock edge.
// - strobe returning high selects the module whose slot was shifted in.
// - with several chassis only the matching chassis number selects.
// - chassis address zero accepts any chassis number.
// - deselect restores the identification register to its initial value.
// - after all 32 identification bits, output only zeros until reload.
// - while selected in data mode each rising edge shifts in data.
// - identification read needs select line high, else config captures junk.
// - after each read clock pulse the output shows the next id bit.
// - configuration is sixteen-bit shift register loaded only selected in data mode.
// - serial clock idles high, data latched on second edge of each bit.
// - strobe low routes serial stream to slot-select, high to the module.
module mss_serial_port
  import mss_pkg::*;
#(
  parameter logic [SLOT_W-1:0] MODULE_SLOT = 5'h01,
  parameter logic [CHAS_W-1:0] CHASSIS_ADDR = 5'h00,
  // arbitrary identification value
  parameter logic [ID_W-1:0] ID_VALUE = 32'h1234_5678
) (
  // system clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // serial link from the master
  input wire logic serial_shift_clock_i,
  input wire logic serial_data_input_i,
  input wire logic data_address_select_i,
  input wire logic slot_zero_strobe_n_i,
  output logic serial_data_output_o,
  output logic serial_data_output_oe_n_o,
  // scanning
  input wire logic scan_advance_clock_i,
  // module side
  output logic module_select_n_o,
  output mss_ctl_s ctl_o
);

  ////////////////////////////////////////////////////////////////////////////
  // address match, shared by both domains

  function automatic logic slot_match(input logic [SEL_W-1:0] w);
    logic [SLOT_W-1:0] s;
    logic [CHAS_W-1:0] c;
    s = w[SLOT_LSB +: SLOT_W];
    c = w[CHAS_LSB +: CHAS_W];
    slot_match = (s == MODULE_SLOT) &&
                 ((CHASSIS_ADDR == CHAS_ANY) || (c == CHASSIS_ADDR));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link domain: runs only while the master clocks, so every state change
  // here is tied to a rising serial edge

  mss_link_s lnk_q;
  mss_link_s lnk_d;
  logic link_sel;
  logic rd_mode;

  // the master settles strobe and data before each rising edge, so the
  // link logic samples them directly on its own clock
  assign link_sel = slot_zero_strobe_n_i && slot_match(lnk_q.slot_sh);
  assign rd_mode = link_sel && (data_address_select_i == DAS_ADDR);

  always_comb begin
    lnk_d = lnk_q;
    if (!slot_zero_strobe_n_i) begin
      // msb first, so shift toward the top
      lnk_d.slot_sh = {lnk_q.slot_sh[SEL_W-2:0], serial_data_input_i};
      lnk_d.id_sh = ID_VALUE;
      lnk_d.out_bit = 1'b0;
    end else if (link_sel) begin
      if (data_address_select_i == DAS_DATA) begin
        // a dropped select line during a read lands here as well
        lnk_d.cfg_sh = {lnk_q.cfg_sh[CFG_W-2:0], serial_data_input_i};
      end else begin
        lnk_d.out_bit = lnk_q.id_sh[ID_W-1];
        lnk_d.id_sh = {lnk_q.id_sh[ID_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge serial_shift_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lnk_q <= '{slot_sh: SEL_RST, cfg_sh: CFG_RST, id_sh: ID_VALUE,
                 out_bit: 1'b0};
    end else begin
      lnk_q <= lnk_d;
    end
  end

  assign serial_data_output_o = lnk_q.out_bit;
  // enable only while this module answers a read; low means driving
  assign serial_data_output_oe_n_o = !rd_mode;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: select, configuration latch and channel counter

  mss_sys_s sys_q;
  mss_sys_s sys_d;
  logic strb_s;
  logic strb_rise;
  logic strb_fall;
  logic scan_rise;

  // strb_sync[0] and scan_sync[0] are first stages, read by the next only
  assign strb_s = sys_q.strb_sync[1];
  assign scan_rise = sys_q.scan_sync[1] && !sys_q.scan_sync[2];

  logic strb_prev_q;
  logic strb_prev_d;
  assign strb_fall = strb_prev_q && !strb_s;
  // select is decided once per strobe rise, from the quiet slot word
  assign strb_rise = strb_s && !strb_prev_q;

  always_comb begin
    sys_d = sys_q;
    strb_prev_d = strb_s;
    sys_d.strb_sync = {sys_q.strb_sync[0], slot_zero_strobe_n_i};
    sys_d.scan_sync = {sys_q.scan_sync[SCAN_W-2:0], scan_advance_clock_i};
    if (!strb_s) begin
      sys_d.selected = 1'b0;
    end else if (strb_rise) begin
      // slot word is quiet while the strobe is high, so it is safe to copy
      sys_d.slot_cap = lnk_q.slot_sh;
      sys_d.selected = slot_match(lnk_q.slot_sh);
    end
    if (strb_fall && sys_q.selected) begin
      // shift register is frozen once the link view drops select
      sys_d.cfg_lat = lnk_q.cfg_sh;
    end
    if (scan_rise) begin
      sys_d.mux_cnt = sys_q.mux_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // strobe history starts at its idle high level; a low start would
      // fake a strobe rise after reset and could select slot zero
      sys_q <= '{strb_sync: '1, scan_sync: '0, slot_cap: SEL_RST,
                 selected: 1'b0, cfg_lat: CFG_RST, mux_cnt: '0};
      strb_prev_q <= 1'b1;
    end else begin
      sys_q <= sys_d;
      strb_prev_q <= strb_prev_d;
    end
  end

  assign module_select_n_o = !sys_q.selected;
  assign ctl_o = '{cfg: sys_q.cfg_lat, mux: sys_q.mux_cnt};

  ////////////////////////////////////////////////////////////////////////////
  // link-domain checks

  a_slot_shift_in: assert property (
    @(posedge serial_shift_clock_i) disable iff (!arst_n_i)
    !slot_zero_strobe_n_i |=>
      lnk_q.slot_sh[0] == $past(serial_data_input_i) &&
      lnk_q.slot_sh[SEL_W-1:1] == $past(lnk_q.slot_sh[SEL_W-2:0]))
    else $error("slot word did not shift in msb first");

  a_id_reload_deselect: assert property (
    @(posedge serial_shift_clock_i) disable iff (!arst_n_i)
    !slot_zero_strobe_n_i |=> lnk_q.id_sh == ID_VALUE)
    else $error("id register not restored on deselect");

  a_id_zero_fill: assert property (
    @(posedge serial_shift_clock_i) disable iff (!arst_n_i)
    (rd_mode && lnk_q.id_sh == '0) |=> (lnk_q.out_bit == 1'b0))
    else $error("nonzero bit after id exhausted");

  a_id_bit_order: assert property (
    @(posedge serial_shift_clock_i) disable iff (!arst_n_i)
    rd_mode |=> lnk_q.out_bit == $past(lnk_q.id_sh[ID_W-1]))
    else $error("read bit is not the next id bit");

  a_cfg_write_shift: assert property (
    @(posedge serial_shift_clock_i) disable iff (!arst_n_i)
    (link_sel && data_address_select_i == DAS_DATA) |=>
      lnk_q.cfg_sh[0] == $past(serial_data_input_i))
    else $error("config bit not captured while selected");

  a_cfg_hold_idle: assert property (
    @(posedge serial_shift_clock_i) disable iff (!arst_n_i)
    !(link_sel && data_address_select_i == DAS_DATA) |=>
      $stable(lnk_q.cfg_sh))
    else $error("config shift register moved while not addressed");

  // the return line must stay released while the stream goes to slot zero
  a_oe_strobe_low: assert property (
    @(posedge serial_shift_clock_i) disable iff (!arst_n_i)
    !slot_zero_strobe_n_i |->
      serial_data_output_oe_n_o)
    else $error("output driven while strobe low");

  a_out_zero_slot: assert property (
    @(posedge serial_shift_clock_i) disable iff (!arst_n_i)
    !slot_zero_strobe_n_i |=>
      serial_data_output_o == 1'b0)
    else $error("output bit not cleared while strobe low");

  a_id_shift_left: assert property (
    @(posedge serial_shift_clock_i) disable iff (!arst_n_i)
    rd_mode |=>
      lnk_q.id_sh == {$past(lnk_q.id_sh[ID_W-2:0]), 1'b0})
    else $error("id register did not shift in zeros");

  a_slot_hold_high: assert property (
    @(posedge serial_shift_clock_i) disable iff (!arst_n_i)
    slot_zero_strobe_n_i |=>
      $stable(lnk_q.slot_sh))
    else $error("slot word moved while strobe high");

  a_out_hold_idle: assert property (
    @(posedge serial_shift_clock_i) disable iff (!arst_n_i)
    (slot_zero_strobe_n_i && !rd_mode) |=>
      $stable(lnk_q.out_bit))
    else $error("output bit moved outside a read");

  ////////////////////////////////////////////////////////////////////////////
  // system-domain checks

  a_mux_advance: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    scan_rise |=> sys_q.mux_cnt == $past(sys_q.mux_cnt) + 1'b1)
    else $error("mux counter did not advance on scan edge");

  a_mux_steady: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    !scan_rise |=> $stable(sys_q.mux_cnt))
    else $error("mux counter moved without scan edge");

  a_select_drop: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    !slot_zero_strobe_n_i [*3] |-> ##1 module_select_n_o)
    else $error("select not removed while strobe low");

  a_select_match: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (strb_s && !strb_prev_q && slot_match(lnk_q.slot_sh)) |=>
      !module_select_n_o [*1])
    else $error("matching slot not selected");

  a_cfg_latch_update: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (strb_fall && sys_q.selected) |=> ctl_o.cfg == $past(lnk_q.cfg_sh))
    else $error("config latch not loaded at deselect");

  // a partial shift must never reach the latch outside a deselect
  a_cfg_latch_hold: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    !(strb_fall && sys_q.selected) |=>
      $stable(ctl_o.cfg))
    else $error("config latch moved outside deselect");

  a_select_strobe_low: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    !strb_s |=>
      module_select_n_o)
    else $error("select kept while synced strobe low");

  a_select_only_rise: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (strb_s && !strb_rise) |=>
      $stable(module_select_n_o))
    else $error("select changed without strobe rise");

  a_slot_cap_copy: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    strb_rise |=>
      sys_q.slot_cap == $past(lnk_q.slot_sh))
    else $error("slot word not captured at strobe rise");

  c_select_seen: cover property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    $fell(module_select_n_o));
  c_cfg_latched: cover property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    strb_fall && sys_q.selected);
  c_id_exhausted: cover property (
    @(posedge serial_shift_clock_i) disable iff (!arst_n_i)
    rd_mode && lnk_q.id_sh == '0);
  c_mux_wrap: cover property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    scan_rise && sys_q.mux_cnt == '1);
  c_read_start: cover property (
    @(posedge serial_shift_clock_i) disable iff (!arst_n_i)
    rd_mode && lnk_q.id_sh == ID_VALUE);

endmodule // mss_serial_port

// File: testbench/mss_master_model.sv
`timescale 1ns/100ps
// acquisition board as serial master; link clock 31 ns, idle high
module mss_master_model (
  // serial link towards the module
  output logic sclk_o,
  output logic sdi_o,
  output logic das_o,
  output logic strobe_n_o,
  // read-back wire
  input wire logic sdo_i
);
  initial begin
    sclk_o = 1'b1;
    sdi_o = 1'b0;
    das_o = 1'b1;
    strobe_n_o = 1'b1;
  end

  // data before the low pulse, sampled by the module on the rise
  task automatic send(input logic d, input logic [31:0] w, input int n,
                      output logic [31:0] r);
    r = 32'h0000_0000;
    das_o = d;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o = w[i];
      #15 sclk_o = 1'b0;
      #15 sclk_o = 1'b1;
      #1 r = {r[30:0], sdo_i};
    end
    // released data line shows the inverse, never a stale level
    sdi_o = ~sdi_o;
  endtask

  task automatic select(input logic [15:0] w);
    logic [31:0] r;
    strobe_n_o = 1'b0;
    #30 send(1'b1, {16'h0000, w}, 16, r);
    #30 strobe_n_o = 1'b1;
  endtask

  // end of transaction: strobe low, then park zero in the slot-select
  task automatic finish_xfer();
    select(16'h0000);
  endtask
endmodule // mss_master_model

// File: testbench/mss_serial_port_test.sv
`timescale 1ns/100ps
module mss_serial_port_test;
  import mss_pkg::*;
  localparam logic [ID_W-1:0] ID = 32'h5a3c_96e1; // arbitrary value
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic scan_advance_clock_i = 1'b0;
  logic sclk, sdi, das, strb_n, sdo, sdo_oe_n, sel_n, sdo_w;
  mss_ctl_s ctl;
  logic sel2_n, sdo2, sdo2_oe_n;
  mss_ctl_s ctl2;
  logic [31:0] r;
  int bad_count = 0;
  int comparisons = 0;
`define CHK(nm, exp, got) begin comparisons++; \
  if ((got) !== (exp)) begin bad_count++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end

  always #50 sys_clk_i = ~sys_clk_i;
  // open-collector return line pulls high when not driven
  assign sdo_w = sdo_oe_n ? 1'b1 : sdo;

  mss_serial_port #(.MODULE_SLOT(5'h01), .CHASSIS_ADDR(5'h09),
    .ID_VALUE(ID)) mss_serial_port_i (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .serial_shift_clock_i(sclk), .serial_data_input_i(sdi),
    .data_address_select_i(das), .slot_zero_strobe_n_i(strb_n),
    .serial_data_output_o(sdo), .serial_data_output_oe_n_o(sdo_oe_n),
    .scan_advance_clock_i(scan_advance_clock_i),
    .module_select_n_o(sel_n), .ctl_o(ctl));
  // second module at slot 2 in a chassis that takes any chassis number
  mss_serial_port #(.MODULE_SLOT(5'h02), .CHASSIS_ADDR(CHAS_ANY),
    .ID_VALUE(ID)) mss_serial_port_any_i (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .serial_shift_clock_i(sclk), .serial_data_input_i(sdi),
    .data_address_select_i(das), .slot_zero_strobe_n_i(strb_n),
    .serial_data_output_o(sdo2), .serial_data_output_oe_n_o(sdo2_oe_n),
    .scan_advance_clock_i(scan_advance_clock_i),
    .module_select_n_o(sel2_n), .ctl_o(ctl2));
  mss_master_model mss_master_model_i (.sclk_o(sclk), .sdi_o(sdi),
    .das_o(das), .strobe_n_o(strb_n), .sdo_i(sdo_w));

  task automatic wait_sys(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_cfg();
    mss_master_model_i.select(16'h0901);
    wait_sys(5);
    `CHK("sel_n", 1'b0, sel_n)
    mss_master_model_i.send(DAS_DATA, 32'h0000_830f, 16, r);
    wait_sys(6);
    `CHK("cfg held", CFG_RST, ctl.cfg)
    mss_master_model_i.finish_xfer();
    wait_sys(6);
    `CHK("sel_n off", 1'b1, sel_n)
    `CHK("cfg", 16'h830f, ctl.cfg)
    $display("test cfg done");
  endtask

  task automatic t_id();
    mss_master_model_i.select(16'h0901);
    wait_sys(5);
    `CHK("oe_n", 1'b0, sdo_oe_n)
    mss_master_model_i.send(DAS_ADDR, 32'h0000_0000, 32, r);
    `CHK("id", ID, r)
    mss_master_model_i.send(DAS_ADDR, 32'h0000_0000, 3, r);
    `CHK("id tail", 3'b000, r[2:0])
    mss_master_model_i.finish_xfer();
    mss_master_model_i.select(16'h0901);
    wait_sys(5);
    mss_master_model_i.send(DAS_ADDR, 32'h0000_0000, 4, r);
    `CHK("id again", ID[31:28], r[3:0])
    mss_master_model_i.finish_xfer();
    wait_sys(6);
    `CHK("cfg kept", 16'h830f, ctl.cfg)
    $display("test id done");
  endtask

  task automatic t_miss();
    logic [15:0] w [2] = '{16'h0301, 16'h0902};
    logic e2 [2] = '{1'b1, 1'b0};
    foreach (w[i]) begin
      mss_master_model_i.select(w[i]);
      wait_sys(5);
      `CHK("sel_n miss", 1'b1, sel_n)
      `CHK("sel2_n any", e2[i], sel2_n)
      `CHK("oe_n miss", 1'b1, sdo_oe_n)
      mss_master_model_i.send(DAS_DATA, 32'h0000_1234, 16, r);
      mss_master_model_i.finish_xfer();
      wait_sys(6);
      `CHK("cfg miss", 16'h830f, ctl.cfg)
      `CHK("cfg any", (i ? 16'h1234 : CFG_RST), ctl2.cfg)
    end
    $display("test miss done");
  endtask

  task automatic t_scan();
    `CHK("mux rst", 2'h0, ctl.mux)
    repeat (5) begin
      scan_advance_clock_i <= 1'b1;
      wait_sys(2);
      scan_advance_clock_i <= 1'b0;
      wait_sys(2);
    end
    wait_sys(5);
    `CHK("mux", 2'h1, ctl.mux)
    $display("test scan done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    bad_count++;
    print_verdict();
  end

  initial begin
    wait_sys(2);
    arst_n_i <= 1'b1;
    wait_sys(3);
    `CHK("sel_n rst", 1'b1, sel_n)
    `CHK("cfg rst", CFG_RST, ctl.cfg)
    t_scan();
    t_cfg();
    t_id();
    t_miss();
    print_verdict();
  end
endmodule // mss_serial_port_test
